//--- common/hbp_if.sv
interface hbp_if;
  logic [hbp_pkg::HI_W-1:0]   addr_hi;
  logic                       address_lsb;
  logic                       data_strobe_n;
  logic                       bus_mode_select;
  logic                       width_16;
  logic                       rd_n;
  logic                       wr_n;
  logic                       rw;
  logic                       cs_n;
  logic [hbp_pkg::DATA_W-1:0] host_d;
  logic                       host_d_oe;
  logic [hbp_pkg::DATA_W-1:0] dev_d;
  logic                       dev_d_oe;
  logic                       dev_ack;
  logic                       dev_ack_oe;
  logic [hbp_pkg::DATA_W-1:0] data_bus;
  logic                       ack_n;

  // resolved wires, pulled up when nobody drives
  assign data_bus = dev_d_oe ? dev_d : (host_d_oe ? host_d : hbp_pkg::DATA_PULL);
  assign ack_n    = dev_ack_oe ? dev_ack : 1'b1;

  modport host (
    output addr_hi, address_lsb, data_strobe_n, bus_mode_select, width_16,
    output rd_n, wr_n, rw, cs_n, host_d, host_d_oe,
    input  data_bus, ack_n
  );

  modport device (
    input  addr_hi, address_lsb, data_strobe_n, bus_mode_select, width_16,
    input  rd_n, wr_n, rw, cs_n, data_bus,
    output dev_d, dev_d_oe, dev_ack, dev_ack_oe
  );
endinterface : hbp_if

//--- common/hbp_pkg.sv
package hbp_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam int HI_W   = ADDR_W - 1;
  localparam int AD_W   = HI_W + DATA_W;

  // control pin sample vector layout
  localparam int CTL_W  = 7;
  localparam int CB_CS  = 6;
  localparam int CB_RD  = 5;
  localparam int CB_WR  = 4;
  localparam int CB_RW  = 3;
  localparam int CB_STB = 2;
  localparam int CB_LSB = 1;
  localparam int CB_WID = 0;
  localparam logic [CTL_W-1:0] CTL_IDLE = 7'h7F;
  localparam logic [AD_W-1:0]  AD_IDLE  = 23'h000000;

  localparam logic [1:0] LANE_NONE = 2'h0;
  localparam logic [1:0] LANE_LO   = 2'h1;
  localparam logic [1:0] LANE_HI   = 2'h2;
  localparam logic [DATA_W-1:0] DATA_PULL = 16'hFFFF;
  localparam logic [DATA_W-1:0] DATA_ZERO = 16'h0000;
  localparam logic [7:0]        BYTE_ZERO = 8'h00;

  // host phase length: least time, rounded up to whole cycles
  localparam int CLK_NS    = 50;
  localparam int PHASE_NS  = 100;
  localparam int PHASE_CYC = (PHASE_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W     = 4;

  typedef enum logic [1:0] {
    HBP_MODE_MOT,
    HBP_MODE_INTEL,
    HBP_MODE_MUX
  } hbp_mode_t;

  typedef enum {
    HBP_D_IDLE,
    HBP_D_REQ,
    HBP_D_HOLD
  } hbp_dev_state_t;

  typedef enum {
    HBP_H_IDLE,
    HBP_H_ALE_HI,
    HBP_H_ALE_LO,
    HBP_H_SETUP,
    HBP_H_STROBE,
    HBP_H_RELEASE
  } hbp_host_state_t;

endpackage : hbp_pkg

//--- design/hbp_device.sv
// What this block does
// - bus mode pin high: Motorola, separate buses
// - bus mode pin low: Intel, separate buses
// - mode pin falling edge selects Intel multiplexed
// - multiplexed: latch address on mode pin falling edge
// - system wires address inputs to data lines
// - 8-bit part on 16-bit bus: shifted wiring
// - 8-bit Intel and Motorola: lsb pin is A0
// - Intel 16-bit: low enable marks low lane
// - Intel high enable marks high lane; 8-bit ignores
// - Motorola 16-bit: two lane strobes, active low
// - Motorola 8-bit: one data strobe times access
// - Intel read strobe: drive register data out
// - Motorola master holds read/write through strobe
// - respond to strobes only while chip selected
// - drive data lines only for read data
// - decode address to exactly one register
// - width pin low 8-bit, high 16-bit
// - Intel master holds write data during strobe
// - acknowledge until strobe or select ends; else float
module hbp_device (
  input  wire logic                       clk,
  input  wire logic                       rst_n,
  hbp_if.device                           bus,
  output logic [hbp_pkg::ADDR_W-1:0]      reg_addr,
  output logic [1:0]                      reg_be,
  output logic [hbp_pkg::DATA_W-1:0]      reg_wdata,
  output logic                            reg_wr,
  output logic                            reg_rd,
  input  wire logic [hbp_pkg::DATA_W-1:0] reg_rdata,
  output logic                            mux_mode
);

  logic [hbp_pkg::CTL_W-1:0]  ctl_s1;
  logic [hbp_pkg::CTL_W-1:0]  ctl_s2;
  logic [hbp_pkg::AD_W-1:0]   ad_s1;
  logic [hbp_pkg::AD_W-1:0]   ad_s2;
  logic                       bm_s1;
  logic                       bm_s2;
  logic                       bm_d_r;
  logic                       mux_r;
  logic [hbp_pkg::ADDR_W-1:0] alat_r;
  hbp_pkg::hbp_dev_state_t    st_r;
  logic [hbp_pkg::DATA_W-1:0] d_o_r;
  logic                       d_oe_r;
  logic                       ack_r;
  logic                       ack_oe_r;

  logic                       mot;
  logic                       w16;
  logic                       cs_act;
  logic                       strobe;
  logic                       is_read;
  logic [1:0]                 be;
  logic                       lsb;
  logic                       stb_n;
  logic [hbp_pkg::HI_W-1:0]   ahi;
  logic [hbp_pkg::DATA_W-1:0] din;
  logic [hbp_pkg::ADDR_W-1:0] acc_addr;
  logic                       start;
  logic                       acc_end;

  assign bus.dev_d      = d_o_r;
  assign bus.dev_d_oe   = d_oe_r;
  assign bus.dev_ack    = ack_r;
  assign bus.dev_ack_oe = ack_oe_r;
  assign mux_mode       = mux_r;

  // two-stage pin synchronisers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctl_s1 <= hbp_pkg::CTL_IDLE;
      ctl_s2 <= hbp_pkg::CTL_IDLE;
      ad_s1  <= hbp_pkg::AD_IDLE;
      ad_s2  <= hbp_pkg::AD_IDLE;
      bm_s1  <= 1'b0;
      bm_s2  <= 1'b0;
    end else begin
      ctl_s1 <= {bus.cs_n, bus.rd_n, bus.wr_n, bus.rw,
                 bus.data_strobe_n, bus.address_lsb, bus.width_16};
      ctl_s2 <= ctl_s1;
      ad_s1  <= {bus.addr_hi, bus.data_bus};
      ad_s2  <= ad_s1;
      bm_s1  <= bus.bus_mode_select;
      bm_s2  <= bm_s1;
    end
  end

  // a falling edge on the mode pin locks multiplexed mode until reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bm_d_r <= 1'b0;
      mux_r  <= 1'b0;
    end else begin
      bm_d_r <= bm_s2;
      if (bm_d_r && !bm_s2) begin
        mux_r <= 1'b1;
      end
    end
  end

  // address latch, wired from the shared data lines by the system
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      alat_r <= '0;
    end else if (bm_d_r && !bm_s2) begin
      alat_r <= {ahi, lsb};
    end
  end

  always_comb begin
    lsb     = ctl_s2[hbp_pkg::CB_LSB];
    stb_n   = ctl_s2[hbp_pkg::CB_STB];
    ahi     = ad_s2[hbp_pkg::AD_W-1:hbp_pkg::DATA_W];
    din     = ad_s2[hbp_pkg::DATA_W-1:0];
    w16     = ctl_s2[hbp_pkg::CB_WID];
    cs_act  = ~ctl_s2[hbp_pkg::CB_CS];
    mot     = bm_s2 & ~mux_r;
    if (mot) begin
      is_read = ctl_s2[hbp_pkg::CB_RW];
      if (w16) begin
        be     = {~lsb, ~stb_n};
        strobe = |be;
      end else begin
        be     = hbp_pkg::LANE_LO;
        strobe = ~stb_n;
      end
    end else begin
      is_read = ~ctl_s2[hbp_pkg::CB_RD];
      strobe  = ~ctl_s2[hbp_pkg::CB_RD] | ~ctl_s2[hbp_pkg::CB_WR];
      be      = w16 ? {~stb_n, ~lsb} : hbp_pkg::LANE_LO;
    end
    acc_addr = mux_r ? alat_r : {ahi, lsb};
    if (w16) begin
      acc_addr[0] = (be == hbp_pkg::LANE_HI);
    end
    start   = cs_act && strobe && (be != hbp_pkg::LANE_NONE);
    acc_end = !cs_act || !strobe;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= hbp_pkg::HBP_D_IDLE;
    end else begin
      case (st_r)
        hbp_pkg::HBP_D_IDLE: if (start) st_r <= hbp_pkg::HBP_D_REQ;
        hbp_pkg::HBP_D_REQ:  st_r <= hbp_pkg::HBP_D_HOLD;
        hbp_pkg::HBP_D_HOLD: if (acc_end) st_r <= hbp_pkg::HBP_D_IDLE;
        default:             st_r <= hbp_pkg::HBP_D_IDLE;
      endcase
    end
  end

  // one request pulse per strobe, one target register per access
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_addr  <= '0;
      reg_be    <= hbp_pkg::LANE_NONE;
      reg_wdata <= hbp_pkg::DATA_ZERO;
      reg_wr    <= 1'b0;
      reg_rd    <= 1'b0;
    end else begin
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      if (st_r == hbp_pkg::HBP_D_IDLE && start) begin
        reg_addr  <= acc_addr;
        reg_be    <= be;
        reg_wdata <= w16 ? din : {hbp_pkg::BYTE_ZERO, din[7:0]};
        reg_wr    <= ~is_read;
        reg_rd    <= is_read;
      end
    end
  end

  // read data is taken while the read pulse stands
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      d_o_r  <= hbp_pkg::DATA_ZERO;
      d_oe_r <= 1'b0;
    end else if (st_r == hbp_pkg::HBP_D_REQ) begin
      d_o_r  <= w16 ? reg_rdata : {hbp_pkg::BYTE_ZERO, reg_rdata[7:0]};
      d_oe_r <= reg_rd;
    end else if (st_r != hbp_pkg::HBP_D_HOLD || acc_end) begin
      d_oe_r <= 1'b0;
    end
  end

  // acknowledge floats outside accesses, driven high then low
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_r    <= 1'b1;
      ack_oe_r <= 1'b0;
    end else begin
      case (st_r)
        hbp_pkg::HBP_D_IDLE: begin
          ack_r    <= 1'b1;
          ack_oe_r <= start;
        end
        hbp_pkg::HBP_D_REQ: begin
          ack_r    <= 1'b0;
          ack_oe_r <= 1'b1;
        end
        hbp_pkg::HBP_D_HOLD: begin
          if (acc_end) begin
            ack_r    <= 1'b1;
            ack_oe_r <= 1'b0;
          end
        end
        default: begin
          ack_r    <= 1'b1;
          ack_oe_r <= 1'b0;
        end
      endcase
    end
  end

endmodule : hbp_device

//--- design/hbp_host.sv
module hbp_host (
  input  wire logic                       clk,
  input  wire logic                       rst_n,
  hbp_if.host                             bus,
  input  wire hbp_pkg::hbp_mode_t         cfg_mode,
  input  wire logic                       cfg_width16,
  input  wire logic                       cmd_valid,
  input  wire logic                       cmd_write,
  input  wire logic [hbp_pkg::ADDR_W-1:0] cmd_addr,
  input  wire logic [1:0]                 cmd_be,
  input  wire logic [hbp_pkg::DATA_W-1:0] cmd_wdata,
  output logic                            cmd_ready,
  output logic                            rsp_valid,
  output logic [hbp_pkg::DATA_W-1:0]      rsp_rdata
);

  hbp_pkg::hbp_host_state_t   st_r;
  hbp_pkg::hbp_mode_t         mode_r;
  logic                       w16_r;
  logic                       wr_r;
  logic [hbp_pkg::ADDR_W-1:0] a_r;
  logic [1:0]                 be_r;
  logic [hbp_pkg::DATA_W-1:0] wd_r;
  logic [hbp_pkg::CNT_W-1:0]  cnt_r;
  logic [1:0]                 ack_s;
  logic [hbp_pkg::DATA_W-1:0] d_s1, d_s2;
  logic                       cs_n_r, rd_n_r, wr_n_r, rw_r, stb_r, lsb_r;
  logic                       bm_r, wid_r, d_oe_r;
  logic [hbp_pkg::HI_W-1:0]   ahi_r;
  logic [hbp_pkg::DATA_W-1:0] d_o_r;
  logic                       mot, p39, p44, phase_done, acked;

  assign bus.cs_n            = cs_n_r;
  assign bus.rd_n            = rd_n_r;
  assign bus.wr_n            = wr_n_r;
  assign bus.rw              = rw_r;
  assign bus.data_strobe_n   = stb_r;
  assign bus.address_lsb     = lsb_r;
  assign bus.bus_mode_select = bm_r;
  assign bus.width_16        = wid_r;
  assign bus.addr_hi         = ahi_r;
  assign bus.host_d          = d_o_r;
  assign bus.host_d_oe       = d_oe_r;

  // shared pin levels while the strobe is active
  always_comb begin
    mot = (mode_r == hbp_pkg::HBP_MODE_MOT);
    if (w16_r) begin
      p39 = mot ? ~be_r[1] : ~be_r[0];
      p44 = mot ? ~be_r[0] : ~be_r[1];
    end else begin
      p39 = a_r[0];
      p44 = ~mot;
    end
    phase_done = (cnt_r == hbp_pkg::CNT_W'(hbp_pkg::PHASE_CYC));
    acked      = ~ack_s[1];
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_s <= 2'h3;
      d_s1  <= hbp_pkg::DATA_ZERO;
      d_s2  <= hbp_pkg::DATA_ZERO;
    end else begin
      ack_s <= {ack_s[0], bus.ack_n};
      d_s1  <= bus.data_bus;
      d_s2  <= d_s1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= '0;
    end else if (st_r == hbp_pkg::HBP_H_IDLE || phase_done) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_r + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r      <= hbp_pkg::HBP_H_IDLE;
      mode_r    <= hbp_pkg::HBP_MODE_INTEL;
      w16_r     <= 1'b0;
      wr_r      <= 1'b0;
      a_r       <= '0;
      be_r      <= hbp_pkg::LANE_NONE;
      wd_r      <= hbp_pkg::DATA_ZERO;
      cmd_ready <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_rdata <= hbp_pkg::DATA_ZERO;
    end else begin
      rsp_valid <= 1'b0;
      case (st_r)
        hbp_pkg::HBP_H_IDLE: begin
          cmd_ready <= 1'b1;
          if (cmd_valid && cmd_ready) begin
            cmd_ready <= 1'b0;
            mode_r    <= cfg_mode;
            w16_r     <= cfg_width16;
            wr_r      <= cmd_write;
            a_r       <= cmd_addr;
            be_r      <= cmd_be;
            wd_r      <= cmd_wdata;
            st_r      <= (cfg_mode == hbp_pkg::HBP_MODE_MUX) ? hbp_pkg::HBP_H_ALE_HI
                                                              : hbp_pkg::HBP_H_SETUP;
          end
        end
        hbp_pkg::HBP_H_ALE_HI: if (phase_done) st_r <= hbp_pkg::HBP_H_ALE_LO;
        hbp_pkg::HBP_H_ALE_LO: if (phase_done) st_r <= hbp_pkg::HBP_H_SETUP;
        hbp_pkg::HBP_H_SETUP:  if (phase_done) st_r <= hbp_pkg::HBP_H_STROBE;
        hbp_pkg::HBP_H_STROBE: begin
          if (acked) begin
            rsp_rdata <= wr_r ? hbp_pkg::DATA_ZERO : d_s2;
            rsp_valid <= 1'b1;
            st_r      <= hbp_pkg::HBP_H_RELEASE;
          end
        end
        hbp_pkg::HBP_H_RELEASE: if (!acked) st_r <= hbp_pkg::HBP_H_IDLE;
        default: st_r <= hbp_pkg::HBP_H_IDLE;
      endcase
    end
  end

  // pin drive follows the phase
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cs_n_r <= 1'b1;
      rd_n_r <= 1'b1;
      wr_n_r <= 1'b1;
      rw_r   <= 1'b1;
      stb_r  <= 1'b1;
      lsb_r  <= 1'b1;
      bm_r   <= 1'b0;
      wid_r  <= 1'b0;
      ahi_r  <= '0;
      d_o_r  <= hbp_pkg::DATA_ZERO;
      d_oe_r <= 1'b0;
    end else begin
      case (st_r)
        hbp_pkg::HBP_H_IDLE: begin
          bm_r  <= (cfg_mode == hbp_pkg::HBP_MODE_MOT);
          wid_r <= cfg_width16;
        end
        hbp_pkg::HBP_H_ALE_HI: begin
          bm_r   <= 1'b1;
          ahi_r  <= a_r[hbp_pkg::ADDR_W-1:1];
          lsb_r  <= a_r[0];
          d_o_r  <= {hbp_pkg::BYTE_ZERO, a_r};
          d_oe_r <= 1'b1;
          if (phase_done) bm_r <= 1'b0;
        end
        hbp_pkg::HBP_H_ALE_LO: begin
          if (phase_done) begin
            d_o_r  <= wd_r;
            d_oe_r <= wr_r;
          end
        end
        hbp_pkg::HBP_H_SETUP: begin
          cs_n_r <= 1'b0;
          rw_r   <= ~(mot & wr_r);
          ahi_r  <= a_r[hbp_pkg::ADDR_W-1:1];
          lsb_r  <= (mot && w16_r) ? 1'b1 : p39;
          stb_r  <= mot ? 1'b1 : p44;
          d_o_r  <= wd_r;
          d_oe_r <= wr_r;
          if (phase_done) begin
            lsb_r  <= p39;
            stb_r  <= p44;
            rd_n_r <= mot | wr_r;
            wr_n_r <= mot | ~wr_r;
          end
        end
        hbp_pkg::HBP_H_STROBE: begin
          // rw, data and select held steady until the answer
          if (acked) begin
            cs_n_r <= 1'b1;
            rd_n_r <= 1'b1;
            wr_n_r <= 1'b1;
            stb_r  <= 1'b1;
            lsb_r  <= 1'b1;
            rw_r   <= 1'b1;
            d_oe_r <= 1'b0;
          end
        end
        default: d_oe_r <= 1'b0;
      endcase
    end
  end

endmodule : hbp_host

//--- sim/hbp_assertions.sv
module hbp_assertions (
  input wire logic                       clk,
  input wire logic                       rst_n,
  input wire logic                       cs_n,
  input wire logic                       rd_n,
  input wire logic                       wr_n,
  input wire logic                       rw,
  input wire logic                       data_strobe_n,
  input wire logic                       address_lsb,
  input wire logic                       bus_mode_select,
  input wire logic                       width_16,
  input wire logic                       host_d_oe,
  input wire logic                       dev_d_oe,
  input wire logic                       dev_ack_oe,
  input wire logic                       ack_n,
  input wire logic [hbp_pkg::DATA_W-1:0] data_bus
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [3:0] cs_hi_cnt_r;
  logic       mot_idle;

  // cycles since chip select went high, saturating
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cs_hi_cnt_r <= 4'hF;
    end else if (!cs_n) begin
      cs_hi_cnt_r <= 4'h0;
    end else if (cs_hi_cnt_r != 4'hF) begin
      cs_hi_cnt_r <= cs_hi_cnt_r + 4'h1;
    end
  end

  assign mot_idle = width_16 ? (data_strobe_n & address_lsb) : data_strobe_n;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  AST_DRIVE_NEEDS_CS: assert property (dev_d_oe |-> cs_hi_cnt_r <= 4'h4)
    else $error("data bus driven long after chip select release");
  AST_NO_CONTENTION: assert property (host_d_oe |-> !dev_d_oe)
    else $error("device drives data while host drives it");
  AST_ACK_FLOAT_IDLE: assert property (cs_hi_cnt_r > 4'h4 |-> !dev_ack_oe)
    else $error("acknowledge driven while unused");
  AST_ACK_HOLD: assert property (!ack_n && !cs_n |=> !ack_n)
    else $error("acknowledge dropped while still selected");
  AST_ACK_RELEASE: assert property ($rose(cs_n) |-> ##[1:5] (!dev_ack_oe && !dev_d_oe))
    else $error("device outputs not floated after deselect");
  AST_INTEL_ACK_TIME: assert property (!cs_n && $fell(rd_n & wr_n) |-> ##[2:8] !ack_n)
    else $error("no acknowledge after read or write strobe");
  AST_MOT_ACK_TIME: assert property (!cs_n && bus_mode_select && $fell(mot_idle)
                                     |-> ##[2:8] !ack_n)
    else $error("no acknowledge after data strobe");
  AST_INTEL_READ_DRIVE: assert property (!cs_n && !rd_n && !ack_n |-> dev_d_oe)
    else $error("read acknowledged without data driven");
  AST_MOT_READ_DRIVE: assert property (!cs_n && bus_mode_select && rw && !ack_n
                                       |-> dev_d_oe)
    else $error("read acknowledged without data driven");
  AST_NARROW_UPPER_ZERO: assert property (dev_d_oe && !width_16
                                          |-> data_bus[15:8] == 8'h00)
    else $error("narrow read drives nonzero upper byte");

  cover property (!cs_n && !rd_n && !ack_n);
  cover property (!cs_n && bus_mode_select && !mot_idle && !ack_n);
  cover property ($fell(bus_mode_select) && cs_n);
endmodule : hbp_assertions

//--- sim/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;

  logic                       clk;
  logic                       rst_n;
  hbp_pkg::hbp_mode_t         cfg_mode;
  logic                       cfg_width16;
  logic                       cmd_valid;
  logic                       cmd_write;
  logic [hbp_pkg::ADDR_W-1:0] cmd_addr;
  logic [1:0]                 cmd_be;
  logic [hbp_pkg::DATA_W-1:0] cmd_wdata;
  logic                       cmd_ready;
  logic                       rsp_valid;
  logic [hbp_pkg::DATA_W-1:0] rsp_rdata;
  logic [hbp_pkg::ADDR_W-1:0] reg_addr;
  logic [1:0]                 reg_be;
  logic [hbp_pkg::DATA_W-1:0] reg_wdata;
  logic                       reg_wr;
  logic                       reg_rd;
  logic [hbp_pkg::DATA_W-1:0] reg_rdata;
  logic                       mux_mode;
  int                         err_total;
  int                         checked;
  int                         wr_cnt;
  int                         rd_cnt;
  logic [hbp_pkg::ADDR_W-1:0] wr_addr;
  logic [1:0]                 wr_be;
  logic [hbp_pkg::DATA_W-1:0] wr_data;
  hbp_pkg::hbp_mode_t         modes [3] = '{hbp_pkg::HBP_MODE_INTEL, hbp_pkg::HBP_MODE_MUX,
                                            hbp_pkg::HBP_MODE_MOT};
  logic [7:0]                 addrs [3] = '{8'h01, 8'h7E, 8'hFF};
  logic [1:0]                 lanes [3] = '{2'h1, 2'h2, 2'h3};

  hbp_if hbp_if_i ();

  hbp_host hbp_host_i (.clk(clk), .rst_n(rst_n), .bus(hbp_if_i), .cfg_mode(cfg_mode),
    .cfg_width16(cfg_width16), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
    .cmd_addr(cmd_addr), .cmd_be(cmd_be), .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata));

  hbp_device hbp_device_i (.clk(clk), .rst_n(rst_n), .bus(hbp_if_i), .reg_addr(reg_addr),
    .reg_be(reg_be), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .mux_mode(mux_mode));

  hbp_assertions hbp_assertions_i (.clk(clk), .rst_n(rst_n), .cs_n(hbp_if_i.cs_n),
    .rd_n(hbp_if_i.rd_n), .wr_n(hbp_if_i.wr_n), .rw(hbp_if_i.rw),
    .data_strobe_n(hbp_if_i.data_strobe_n), .address_lsb(hbp_if_i.address_lsb),
    .bus_mode_select(hbp_if_i.bus_mode_select), .width_16(hbp_if_i.width_16),
    .host_d_oe(hbp_if_i.host_d_oe), .dev_d_oe(hbp_if_i.dev_d_oe),
    .dev_ack_oe(hbp_if_i.dev_ack_oe), .ack_n(hbp_if_i.ack_n), .data_bus(hbp_if_i.data_bus));

  // register file stand-in: contents follow the address
  assign reg_rdata = {reg_addr ^ 8'hC3, reg_addr};

  always @(negedge clk) begin
    if (reg_wr === 1'b1) begin
      wr_cnt = wr_cnt + 1;
      wr_addr = reg_addr;
      wr_be = reg_be;
      wr_data = reg_wdata;
    end
    if (reg_rd === 1'b1) begin
      rd_cnt = rd_cnt + 1;
    end
  end

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic stop_test();
    $display("mismatches %0d comparisons %0d", err_total, checked);
    if (err_total == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic timeout();
    err_total++;
    $display("MISMATCH t=%0t handshake timeout", $time);
    stop_test();
  endtask : timeout

  task automatic do_reset(input hbp_pkg::hbp_mode_t m);
    @(negedge clk);
    rst_n = 1'b0;
    cfg_mode = m;
    cfg_width16 = 1'b0;
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
  endtask : do_reset

  task automatic access(input logic wr, input logic [7:0] a, input logic [1:0] be,
                        input logic [15:0] wd, output logic [15:0] rd);
    int n;
    for (n = 0; n < 200 && cmd_ready !== 1'b1; n++) begin
      @(negedge clk);
    end
    if (n == 200) timeout();
    cmd_valid = 1'b1;
    cmd_write = wr;
    cmd_addr = a;
    cmd_be = be;
    cmd_wdata = wd;
    @(negedge clk);
    cmd_valid = 1'b0;
    for (n = 0; n < 400 && rsp_valid !== 1'b1; n++) begin
      @(negedge clk);
    end
    if (n == 400) timeout();
    rd = rsp_rdata;
  endtask : access

  task automatic run_case(input logic [7:0] a, input logic [1:0] be, input logic [15:0] wd);
    logic [15:0] rd;
    logic [15:0] msk;
    logic [7:0]  ea;
    logic [1:0]  eb;
    int          w0;
    int          r0;
    eb = cfg_width16 ? be : 2'h1;
    ea = cfg_width16 ? {a[7:1], be == 2'h2} : a;
    msk = {{8{eb[1]}}, {8{eb[0]}}};
    w0 = wr_cnt;
    r0 = rd_cnt;
    access(1'b1, a, be, wd, rd);
    chk(16'(wr_cnt - w0), 16'h0001, "write pulse count");
    chk({8'h00, wr_addr}, {8'h00, ea}, "write address");
    chk({14'h0000, wr_be}, {14'h0000, eb}, "write lanes");
    chk(wr_data & msk, wd & msk, "write data");
    access(1'b0, a, be, 16'h0000, rd);
    chk(16'(rd_cnt - r0), 16'h0001, "read pulse count");
    chk(rd & msk, {ea ^ 8'hC3, ea} & msk, "read data");
  endtask : run_case

  initial begin
    err_total = 0;
    checked = 0;
    wr_cnt = 0;
    rd_cnt = 0;
    rst_n = 1'b0;
    cfg_mode = hbp_pkg::HBP_MODE_INTEL;
    cfg_width16 = 1'b0;
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    cmd_addr = 8'h00;
    cmd_be = 2'h0;
    cmd_wdata = 16'h0000;
    for (int i = 0; i < 3; i++) begin
      do_reset(modes[i]);
      for (int w = 0; w < 2; w++) begin
        cfg_width16 = w[0];
        for (int k = 0; k < 3; k++) begin
          run_case(addrs[k], w[0] ? lanes[k] : 2'h1,
                   16'hA55A ^ (16'(k) * 16'h1111) ^ 16'(i));
        end
      end
      chk({15'h0000, mux_mode}, {15'h0000, modes[i] == hbp_pkg::HBP_MODE_MUX}, "mux mode");
    end
    stop_test();
  end
endmodule : tb_top
